// file: include/swd_consts.svh
// timing counts, opcode fields and fixed address of the single-wire debug port
`ifndef SWD_CONSTS_SVH
`define SWD_CONSTS_SVH
`define SWD_SAMPLE_CYC 4'h9
`define SWD_PULSE_CYC 4'h7
`define SWD_ZERO_CYC 4'hd
`define SWD_TIMEOUT_CYC 8'hff
`define SWD_OPC_LAST 4'h7
`define SWD_WORD_LAST 4'hf
`define SWD_OP_HW 7
`define SWD_OP_DATA 6
`define SWD_OP_RD 5
`define SWD_OP_WORD 3
`define SWD_OP_MAP 2
`define SWD_TTAGO_HI 4
`define SWD_TTAGO_LO 3
`define SWD_TTAGO_GO 2'h1
`define SWD_TTAGO_TRACE 2'h2
`define SWD_TTAGO_TAG 2'h3
`define SWD_OPC_BKGND 8'h90
`define SWD_STATUS_ADDR 16'hff01
`define SWD_ST_ENABLE 7
`define SWD_ST_ACTIVE 6
`define SWD_FIFO_DEPTH 16
`endif

// file: include/swd_pkg.sv
// types shared by the single-wire debug port
package swd_pkg;
    typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_WDATA, ST_BUS, ST_PUSH, ST_FWRD, ST_TX} swd_state_t;
    typedef struct packed {
        logic is_opcode;
        logic [15:0] value;
    } swd_fw_word_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic write;
        logic word;
        logic dbg_map;
    } swd_mem_cmd_t;
endpackage : swd_pkg

// file: hdl/swd_port.sv
// single-wire debug port: bit engine, command decoder, run control and firmware fifo
// What this block does
// - bits travel msb first, nominally sixteen clocks per bit
// - 256 clocks without a host edge time out and clear the command
// - falling edge synchronised; line sampled nine clocks after perceived start
// - sending one: short high pulse seven clocks after start; host released before
// - sending zero: hold low thirteen clocks, then drive briefly high
// - every command starts with eight-bit opcode; hardware ones run without halting
// - debug keeps the bus until done; multi-cycle access freezes the cpu
// - opcode 90 requests halt, only if firmware commands are enabled
// - E4/EC read with debug resources mapped, address then 16 data bits
// - E0/E8 read the user map, debug resources unmapped
// - C4/CC write with debug resources mapped, address then data
// - C0/C8 write the user map, debug resources unmapped
// - byte data: odd address low byte, even high byte; words aligned
// - status byte reads 00, 80 when enabled, C0 when halted
// - firmware commands only while halted; rom and registers then mapped
// - 62-67 return, 42-47 accept a word: next, pc, d, x, y, sp
// - 08 resumes, 10 steps one instruction, 18 enables tagging and resumes
// - halt request while firmware disabled is dropped and the cpu keeps running
// - halt takes effect at the next instruction boundary
`timescale 1ns/1ns
`include "swd_consts.svh"

module swd_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input wire logic clk, // clock
    input wire logic srst, // synchronous reset
    input wire logic in_valid, // write request
    output logic in_ready, // not full
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // not empty
    input wire logic out_ready, // read request
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    wire logic do_wr = in_valid && in_ready;
    wire logic do_rd = out_valid && out_ready;
    assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(do_wr);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(do_rd);
        end
    end
endmodule : swd_fifo

module swd_port (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic srst, // synchronous reset, active high
    input wire logic debug_wire_pin_in, // wire level
    output logic debug_wire_pin_out, // level driven onto the wire
    output logic debug_wire_pin_oe, // high while the wire is driven
    output logic mem_req, // bus request, held until ack
    output swd_pkg::swd_mem_cmd_t mem_cmd, // access description
    input wire logic mem_ack, // access done
    input wire logic [15:0] mem_rdata, // read data, lanes placed by address
    output logic cpu_freeze, // cpu clocks stopped
    input wire logic cpu_insn_boundary, // pulse at instruction end
    input wire logic cpu_halt_to_debug_instr, // pulse when cpu runs its halt instruction
    input wire logic tag_hit, // pulse when a tagged instruction is reached
    output logic cpu_in_background, // cpu halted for debug
    output logic tag_enable, // tagging armed
    output logic fw_valid, // firmware word waiting
    output swd_pkg::swd_fw_word_t fw_word, // opcode or data word
    input wire logic fw_ready, // firmware takes the word
    input wire logic fw_rd_valid, // firmware read result valid
    input wire logic [15:0] fw_rd_data // firmware read result
);
    swd_pkg::swd_state_t state_reg;
    swd_pkg::swd_state_t ret_reg;
    swd_pkg::swd_fw_word_t push_reg;
    logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic in_bit_reg;
    logic [3:0] cyc_reg;
    logic [7:0] to_cnt_reg;
    logic [3:0] bits_reg;
    logic [15:0] shift_reg, addr_reg, wdata_reg;
    logic [7:0] op_reg;
    logic pin_oe_reg, pin_out_reg, waited_reg;
    logic enable_reg, active_reg, cpu_halt_to_debug_instr_req_reg, step_reg, tag_reg;
    logic fifo_in_ready;

    function automatic logic is_status(input logic [15:0] a, input logic map);
        is_status = map && (a == `SWD_STATUS_ADDR);
    endfunction : is_status

    wire logic fall = pin_prev_reg && !pin_sync_reg;
    wire logic start = fall && !in_bit_reg;
    wire logic tx_mode = state_reg == swd_pkg::ST_TX;
    wire logic tx_bit = shift_reg[15];
    wire logic rx_sample = in_bit_reg && !tx_mode && cyc_reg == `SWD_SAMPLE_CYC;
    wire logic tx_end = in_bit_reg && tx_mode && cyc_reg == `SWD_ZERO_CYC;
    wire logic bit_end = rx_sample || tx_end;
    wire logic timeout = !fall && to_cnt_reg == `SWD_TIMEOUT_CYC;
    wire logic [3:0] cyc_next = start ? 4'h0 : cyc_reg + 4'h1;
    wire logic in_bit_next = start || (in_bit_reg && !bit_end);
    wire logic [15:0] rx_next = {shift_reg[14:0], pin_sync_reg};
    wire logic [7:0] opc = rx_next[7:0];
    wire logic opc_done = state_reg == swd_pkg::ST_OPC && rx_sample && bits_reg == `SWD_OPC_LAST;
    wire logic word_done = rx_sample && bits_reg == `SWD_WORD_LAST;
    wire logic fw_op = opc_done && !opc[`SWD_OP_HW] && active_reg;
    wire logic [1:0] ttago = opc[`SWD_TTAGO_HI:`SWD_TTAGO_LO];
    wire logic op_rd = op_reg[`SWD_OP_RD];
    wire logic st_hit = is_status(addr_reg, op_reg[`SWD_OP_MAP]);
    wire logic in_bus = state_reg == swd_pkg::ST_BUS;
    wire logic st_write = in_bus && st_hit && !op_rd;
    // status sits in the low lane since its address is odd
    wire logic [15:0] st_word = {8'h00, enable_reg, active_reg, 6'h00};
    wire logic enter = (cpu_halt_to_debug_instr_req_reg && cpu_insn_boundary) || (step_reg && cpu_insn_boundary)
        || (tag_reg && tag_hit) || (cpu_halt_to_debug_instr && enable_reg);
    wire logic leave = fw_op && ttago != 2'h0;
    // drive pattern evaluated on the next count so the registered pin lines up
    wire logic tx_on = in_bit_next && tx_mode && !start;
    wire logic oe_next = (tx_mode && start && !tx_bit)
        || (tx_on && (tx_bit ? cyc_next == `SWD_PULSE_CYC : cyc_next <= `SWD_ZERO_CYC));
    wire logic out_next = tx_bit || (tx_on && cyc_next == `SWD_ZERO_CYC);

    assign debug_wire_pin_oe = pin_oe_reg;
    assign debug_wire_pin_out = pin_out_reg;
    assign mem_req = in_bus && !st_hit;
    assign mem_cmd = '{addr: addr_reg, wdata: wdata_reg, write: !op_rd,
                       word: op_reg[`SWD_OP_WORD], dbg_map: op_reg[`SWD_OP_MAP]};
    assign cpu_freeze = mem_req && waited_reg;
    assign cpu_in_background = active_reg;
    assign tag_enable = tag_reg;

    // the edge detector reads only the second and third stage
    always_ff @(posedge ref_clk) begin
        pin_meta_reg <= srst ? 1'b1 : debug_wire_pin_in;
        pin_sync_reg <= srst ? 1'b1 : pin_meta_reg;
        pin_prev_reg <= srst ? 1'b1 : pin_sync_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (srst || timeout) begin
            in_bit_reg <= 1'b0;
            cyc_reg <= 4'h0;
            pin_oe_reg <= 1'b0;
            pin_out_reg <= 1'b0;
        end else begin
            in_bit_reg <= in_bit_next;
            cyc_reg <= cyc_next;
            pin_oe_reg <= oe_next;
            pin_out_reg <= out_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || fall || timeout) begin
            to_cnt_reg <= 8'h00;
        end else begin
            to_cnt_reg <= to_cnt_reg + 8'h01;
        end
        waited_reg <= !srst && mem_req && !mem_ack;
    end

    always_ff @(posedge ref_clk) begin
        if (srst || timeout) begin
            state_reg <= swd_pkg::ST_OPC;
            ret_reg <= swd_pkg::ST_OPC;
            bits_reg <= 4'h0;
            op_reg <= 8'h00;
            shift_reg <= 16'h0000;
            addr_reg <= 16'h0000;
            wdata_reg <= 16'h0000;
            push_reg <= '0;
        end else begin
            if (bit_end) begin
                bits_reg <= bits_reg + 4'h1;
                shift_reg <= rx_sample ? rx_next : {shift_reg[14:0], 1'b0};
            end
            unique case (state_reg)
                swd_pkg::ST_OPC: if (opc_done) begin
                    op_reg <= opc;
                    bits_reg <= 4'h0;
                    if (opc[`SWD_OP_HW] && opc[`SWD_OP_DATA]) begin
                        state_reg <= swd_pkg::ST_ADDR;
                    end else if (fw_op) begin
                        push_reg <= '{is_opcode: 1'b1, value: {8'h00, opc}};
                        state_reg <= swd_pkg::ST_PUSH;
                        ret_reg <= !opc[`SWD_OP_DATA] ? swd_pkg::ST_OPC
                            : opc[`SWD_OP_RD] ? swd_pkg::ST_FWRD : swd_pkg::ST_WDATA;
                    end
                end
                swd_pkg::ST_ADDR: if (word_done) begin
                    addr_reg <= rx_next;
                    state_reg <= op_rd ? swd_pkg::ST_BUS : swd_pkg::ST_WDATA;
                end
                swd_pkg::ST_WDATA: if (word_done) begin
                    wdata_reg <= rx_next;
                    push_reg <= '{is_opcode: 1'b0, value: rx_next};
                    ret_reg <= swd_pkg::ST_OPC;
                    state_reg <= op_reg[`SWD_OP_HW] ? swd_pkg::ST_BUS : swd_pkg::ST_PUSH;
                end
                swd_pkg::ST_BUS: if (st_hit || mem_ack) begin
                    shift_reg <= st_hit ? st_word : mem_rdata;
                    bits_reg <= 4'h0;
                    state_reg <= op_rd ? swd_pkg::ST_TX : swd_pkg::ST_OPC;
                end
                swd_pkg::ST_PUSH: if (fifo_in_ready) begin
                    state_reg <= ret_reg;
                end
                swd_pkg::ST_FWRD: if (fw_rd_valid) begin
                    shift_reg <= fw_rd_data;
                    bits_reg <= 4'h0;
                    state_reg <= swd_pkg::ST_TX;
                end
                swd_pkg::ST_TX: if (tx_end && bits_reg == `SWD_WORD_LAST) begin
                    state_reg <= swd_pkg::ST_OPC;
                end
            endcase
        end
    end

    // run control; a halt request without enable is simply dropped
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            enable_reg <= 1'b0;
            active_reg <= 1'b0;
            cpu_halt_to_debug_instr_req_reg <= 1'b0;
            step_reg <= 1'b0;
            tag_reg <= 1'b0;
        end else begin
            if (st_write) begin
                enable_reg <= wdata_reg[`SWD_ST_ENABLE];
            end
            if (opc_done && opc == `SWD_OPC_BKGND && enable_reg) begin
                cpu_halt_to_debug_instr_req_reg <= 1'b1;
            end else if (cpu_insn_boundary) begin
                cpu_halt_to_debug_instr_req_reg <= 1'b0;
            end
            active_reg <= enter || (active_reg && !leave);
            step_reg <= (leave && ttago == `SWD_TTAGO_TRACE) || (step_reg && !enter);
            tag_reg <= (leave && ttago == `SWD_TTAGO_TAG) || (tag_reg && !enter);
        end
    end

    swd_fifo #(.WIDTH($bits(swd_pkg::swd_fw_word_t)), .DEPTH(`SWD_FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .srst(srst),
        .in_valid(state_reg == swd_pkg::ST_PUSH),
        .in_ready(fifo_in_ready),
        .in_data(push_reg),
        .out_valid(fw_valid),
        .out_ready(fw_ready),
        .out_data(fw_word)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_rx_start;
        start && !tx_mode && !timeout;
    endsequence
    sequence s_tx_start(logic b);
        start && tx_mode && tx_bit == b && !timeout;
    endsequence

    AST_RX_WINDOW: assert property (
        s_rx_start |=> in_bit_reg [*8] ##1 in_bit_reg
        ##1 (in_bit_reg && rx_sample) ##1 !in_bit_reg)
        else $error("receive sample not at the ninth clock");
    AST_ONE_PULSE: assert property (
        s_tx_start(1'b1) |=> !pin_oe_reg [*7] ##1 (pin_oe_reg && pin_out_reg) ##1 !pin_oe_reg)
        else $error("one bit pulse misplaced");
    AST_ZERO_LOW: assert property (
        s_tx_start(1'b0) |=> (pin_oe_reg && !pin_out_reg) [*8] ##1
        (pin_oe_reg && !pin_out_reg) [*5] ##1 (pin_oe_reg && pin_out_reg) ##1 !pin_oe_reg)
        else $error("zero bit low time wrong");
    AST_TIMEOUT: assert property (
        timeout |=> state_reg == swd_pkg::ST_OPC && bits_reg == 4'h0 && to_cnt_reg == 8'h00)
        else $error("timeout did not clear command");
    AST_STATUS_CODE: assert property (
        st_word == 16'h0000 || st_word == 16'h0080 || st_word == 16'h00c0)
        else $error("status byte has illegal value");
    AST_HALT_ENTRY: assert property (
        cpu_halt_to_debug_instr_req_reg && cpu_insn_boundary |=> active_reg)
        else $error("halt not taken at boundary");
    AST_DROP_REQ: assert property (
        opc_done && opc == `SWD_OPC_BKGND && !enable_reg && !cpu_halt_to_debug_instr_req_reg |=> !cpu_halt_to_debug_instr_req_reg)
        else $error("halt request kept while disabled");
    AST_BUS_HOLD: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
        else $error("bus released before access done");
    AST_FW_HALTED: assert property (
        // a go command drops the halt on the very edge that starts the push
        $rose(state_reg == swd_pkg::ST_PUSH) && push_reg.is_opcode |-> $past(active_reg))
        else $error("firmware command accepted while running");
    AST_TAG_CLEAR: assert property (
        $rose(active_reg) |-> !tag_reg)
        else $error("tagging still armed after halt");
endmodule : swd_port

// file: verification/swd_host_model.sv
// host side model driving the single-wire debug line
`timescale 1ns/1ns
module swd_host_model (
    input wire logic ref_clk, // target clock
    input wire logic wire_lvl, // resolved line level
    output logic host_low // high while the host pulls low
);
    initial host_low = 1'b0;
    task automatic put_bits(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            host_low <= 1'b1;
            repeat (v[i] ? 2 : 14) @(posedge ref_clk);
            host_low <= 1'b0;
            repeat (v[i] ? 14 : 2) @(posedge ref_clk);
        end
    endtask : put_bits
    // longer period: a returned zero ends late
    task automatic get_bits(output logic [15:0] v, input int n);
        v = '0;
        for (int i = n - 1; i >= 0; i--) begin
            host_low <= 1'b1;
            repeat (2) @(posedge ref_clk);
            host_low <= 1'b0;
            repeat (7) @(posedge ref_clk);
            @(negedge ref_clk);
            v[i] = wire_lvl;
            repeat (15) @(posedge ref_clk);
        end
    endtask : get_bits
endmodule : swd_host_model

// file: verification/tb.sv
// testbench for the single-wire debug port
`timescale 1ns/1ns
module tb;
    logic ref_clk, srst, host_low, wire_lvl, pin_out, pin_oe;
    logic mem_req, mem_ack, cpu_freeze, insn_b, halt_in, tag_hit;
    logic bg, tag_en, fw_valid, fw_ready, fw_rd_valid, freeze_seen;
    logic [15:0] mem_rdata, fw_rd_data, rd;
    swd_pkg::swd_mem_cmd_t mem_cmd, cmd_seen;
    swd_pkg::swd_fw_word_t fw_word;
    swd_pkg::swd_fw_word_t fw_q[$];
    int fail_count, n_tests, ack_cnt, low_run, last_low;
    logic [7:0] ops[8] = '{8'hc0, 8'hc8, 8'hc4, 8'hcc, 8'he0, 8'he8, 8'he4, 8'hec};
    // pull-up wins whenever nobody drives the line
    assign wire_lvl = pin_oe ? pin_out : !host_low;
    swd_port i_swd_port (.ref_clk(ref_clk), .srst(srst), .debug_wire_pin_in(wire_lvl),
        .debug_wire_pin_out(pin_out), .debug_wire_pin_oe(pin_oe), .mem_req(mem_req),
        .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .cpu_freeze(cpu_freeze), .cpu_insn_boundary(insn_b),
        .cpu_halt_to_debug_instr(halt_in), .tag_hit(tag_hit), .cpu_in_background(bg),
        .tag_enable(tag_en), .fw_valid(fw_valid), .fw_word(fw_word), .fw_ready(fw_ready),
        .fw_rd_valid(fw_rd_valid), .fw_rd_data(fw_rd_data));
    swd_host_model i_swd_host_model (.ref_clk(ref_clk), .wire_lvl(wire_lvl),
        .host_low(host_low));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // slow memory: ack in the fifth request cycle, so the cpu must freeze
    always @(posedge ref_clk) begin
        mem_ack <= mem_req && !mem_ack && ack_cnt == 3;
        if (mem_req && !mem_ack) begin
            freeze_seen <= freeze_seen | cpu_freeze;
            ack_cnt <= (ack_cnt == 3) ? 0 : ack_cnt + 1;
            if (ack_cnt == 3)
                cmd_seen <= mem_cmd;
        end
    end
    always @(posedge ref_clk) begin
        if (fw_valid && fw_ready)
            fw_q.push_back(fw_word);
        if (pin_oe && !pin_out)
            low_run <= low_run + 1;
        else if (low_run != 0) begin
            last_low <= low_run;
            low_run <= 0;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    // f: bit0 address, bit1 write data, bit2 read data
    task automatic cmd(input logic [15:0] op, input logic [15:0] a, input logic [15:0] d,
        input int f);
        i_swd_host_model.put_bits(op, 8);
        if (f[0])
            i_swd_host_model.put_bits(a, 16);
        if (f[1])
            i_swd_host_model.put_bits(d, 16);
        repeat (150) @(posedge ref_clk);
        if (f[2])
            i_swd_host_model.get_bits(rd, 16);
    endtask : cmd
    task automatic pulse(input logic [2:0] w);
        insn_b <= w[0];
        halt_in <= w[1];
        tag_hit <= w[2];
        @(posedge ref_clk);
        insn_b <= 1'b0;
        halt_in <= 1'b0;
        tag_hit <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : pulse
    task automatic t_refused;
        cmd(16'h00e4, 16'hff01, 16'h0000, 5);
        chk("status idle", 16'h0000, rd);
        cmd(16'h0090, 16'h0000, 16'h0000, 0);
        pulse(3'b011);
        chk("halt refused", 1'b0, bg);
        // firmware opcode while running must not reach the fifo
        fw_q.delete();
        cmd(16'h0008, 16'h0000, 16'h0000, 0);
        chk("fw refused", 0, fw_q.size());
    endtask : t_refused
    task automatic t_mem;
        logic [15:0] a;
        for (int i = 0; i < 8; i++) begin
            a = ops[i][3] ? 16'h2002 : 16'h2001;
            mem_rdata <= 16'h5a00 + 16'(i);
            freeze_seen <= 1'b0;
            cmd({8'h00, ops[i]}, a, 16'h00a5 + 16'(i), ops[i][5] ? 5 : 3);
            chk("bus addr", a, cmd_seen.addr);
            chk("bus kind", {!ops[i][5], ops[i][3], ops[i][2]},
                {cmd_seen.write, cmd_seen.word, cmd_seen.dbg_map});
            if (ops[i][5])
                chk("read data", 16'h5a00 + 16'(i), rd);
            else
                chk("write data", 16'h00a5 + 16'(i), cmd_seen.wdata);
            chk("cpu frozen", 1'b1, freeze_seen);
        end
        chk("freeze released", 1'b0, cpu_freeze);
    endtask : t_mem
    task automatic t_enable;
        cmd(16'h00c4, 16'hff01, 16'h0080, 3);
        cmd(16'h00e4, 16'hff01, 16'h0000, 5);
        chk("status enabled", 16'h0080, rd);
        cmd(16'h0090, 16'h0000, 16'h0000, 0);
        chk("halt waits", 1'b0, bg);
        pulse(3'b001);
        chk("halted", 1'b1, bg);
        cmd(16'h00e4, 16'hff01, 16'h0000, 5);
        chk("status halted", 16'h00c0, rd);
    endtask : t_enable
    task automatic t_fifo;
        fw_q.delete();
        fw_ready <= 1'b0;
        for (int i = 0; i < 8; i++)
            cmd(16'h0042 + 16'(i % 6), 16'h0000, 16'h1000 + 16'(i), 2);
        chk("fifo waiting", 1'b1, fw_valid);
        chk("nothing popped", 0, fw_q.size());
        fw_ready <= 1'b1;
        repeat (30) @(posedge ref_clk);
        chk("fifo count", 16, fw_q.size());
        for (int i = 0; i < 8; i++) begin
            chk("fw opcode", {1'b1, 16'h0042 + 16'(i % 6)}, fw_q[2 * i]);
            chk("fw data", {1'b0, 16'h1000 + 16'(i)}, fw_q[2 * i + 1]);
        end
    endtask : t_fifo
    task automatic t_fw_read;
        fw_q.delete();
        fw_rd_data <= 16'hc3a4;
        fw_rd_valid <= 1'b1;
        cmd(16'h0063, 16'h0000, 16'h0000, 4);
        fw_rd_valid <= 1'b0;
        chk("fw read", 16'hc3a4, rd);
        chk("fw read opcode", {1'b1, 16'h0063}, fw_q[0]);
        chk("zero drive cycles", 13, last_low);
    endtask : t_fw_read
    task automatic t_run;
        cmd(16'h0008, 16'h0000, 16'h0000, 0);
        chk("go leaves", 1'b0, bg);
        pulse(3'b011);
        chk("halt instruction", 1'b1, bg);
        cmd(16'h0010, 16'h0000, 16'h0000, 0);
        chk("step runs", 1'b0, bg);
        pulse(3'b001);
        chk("step halts", 1'b1, bg);
        cmd(16'h0018, 16'h0000, 16'h0000, 0);
        chk("tag armed", 2'b10, {tag_en, bg});
        pulse(3'b101);
        chk("tag halts", 2'b01, {tag_en, bg});
    endtask : t_run
    task automatic t_timeout;
        i_swd_host_model.put_bits(16'h0007, 3);
        repeat (300) @(posedge ref_clk);
        cmd(16'h00e4, 16'hff01, 16'h0000, 5);
        chk("after timeout", 16'h00c0, rd);
    endtask : t_timeout
    initial begin
        srst = 1'b1;
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
        insn_b = 1'b0;
        halt_in = 1'b0;
        tag_hit = 1'b0;
        fw_ready = 1'b1;
        fw_rd_valid = 1'b0;
        fw_rd_data = 16'h0000;
        freeze_seen = 1'b0;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("reset outputs", 6'h00, {pin_oe, pin_out, mem_req, bg, tag_en, fw_valid});
        t_refused();
        t_mem();
        t_enable();
        t_fifo();
        t_fw_read();
        t_run();
        t_timeout();
        conclude();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        fail_count++;
        conclude();
    end
endmodule : tb
